// ==== core/fpc_coding.sv ====
/*
  fpc_coding: 100BASE-TX coding layer, transmit and receive, one clock.
  assumes CLK is the serial bit clock; nibbles move once per five bits.
  the analog front end supplies recovered line levels bit-synchronous.
*/
//
// Contract
// - each data nibble maps to its fixed 5-bit code-group.
// - TXEN rising sends J then K in place of first preamble nibbles.
// - TXEN falling sends T then R; idle code-group otherwise.
// - TXER during a frame substitutes halt code-group for data.
// - invalid code-group during receive-data-valid raises RXER.
// - scrambler seed derived from the transceiver address.
// - scrambler serialises each code-group into an NRZI bit stream.
// - NRZI ones step the three-level code; zeros hold level.
// - receive: three-level to NRZI, descramble, deserialise.
// - descrambler key syncs on idle, then locks.
// - no idle within 40 us aborts reception and resyncs.
// - J/K sets code-group alignment, kept until next frame.
// - J/K delivered as two 0101 nibbles; data decoded after.
// - RXDV rises with first translated delimiter nibble.
// - T/R or two idles end CRS and RXDV, not translated.
// - RXDV also drops on link failure or lost signal.
// - unexpected code-group in frame raises RXER.
// - bad start delimiter raises RXER with 1110 and no RXDV.
// - T without R or R without T raises RXER.
// - receive clock runs at nibble rate; data synchronous to it.
// - address defaults 0 or 2 for first, 1 for second.
`timescale 1ns/100ps
module fpc_coding (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // configuration
  input  wire logic [4:0]  PHY_ADDR,
  // transmit MII
  input  wire logic [3:0]  TXD,
  input  wire logic        TXEN,
  input  wire logic        TXER,
  output logic             TX_NIB_STB,
  // transmit line
  output logic [1:0]       TX_LEVEL,
  // receive line
  input  wire logic [1:0]  RX_LEVEL,
  input  wire logic        LINE_SIGNAL_PRESENT,
  input  wire logic        LINK_OK,
  // receive MII
  output logic             RXCLK,
  output logic [3:0]       RXD,
  output logic             RXDV,
  output logic             RXER,
  output logic             CRS
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_q, rst_n;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ************************************************************
  // transmit
  // ************************************************************
  logic [2:0] tbit_q, tbit_d;
  logic [4:0] tsh_q, tsh_d;
  logic [1:0] tstate_q, tstate_d; // 0 idle, 1 sent J, 2 frame, 3 sent T
  logic       tseed_q, tseed_d;
  logic       tkey, tline_bit;
  logic       tcg_end;

  assign tcg_end    = (tbit_q == fpc_pkg::BIT_LAST);
  assign TX_NIB_STB = tcg_end;

  always_comb
  begin
    tbit_d   = tcg_end ? 3'h0 : tbit_q + 3'h1;
    tsh_d    = {tsh_q[3:0], 1'b0};
    tstate_d = tstate_q;
    tseed_d  = 1'b0;
    if (tcg_end)
    begin
      tsh_d = fpc_pkg::CG_IDLE;
      unique case (tstate_q)
        2'h0: if (TXEN) begin tsh_d = fpc_pkg::CG_J; tstate_d = 2'h1; end
        2'h1: begin tsh_d = fpc_pkg::CG_K; tstate_d = 2'h2; end
        2'h2:
          if (!TXEN) begin tsh_d = fpc_pkg::CG_T; tstate_d = 2'h3; end
          else if (TXER) tsh_d = fpc_pkg::CG_H;
          else tsh_d = fpc_pkg::enc4b5b(TXD);
        2'h3: begin tsh_d = fpc_pkg::CG_R; tstate_d = 2'h0; end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbit_q   <= 3'h0;
      tsh_q    <= fpc_pkg::CG_IDLE;
      tstate_q <= 2'h0;
      tseed_q  <= 1'b1;
    end
    else
    begin
      tbit_q   <= tbit_d;
      tsh_q    <= tsh_d;
      tstate_q <= tstate_d;
      tseed_q  <= tseed_d;
    end
  end

  fpc_scram u_tx_scram (
    .clk      (CLK),
    .rst_n    (rst_n),
    .load     (tseed_q),
    .load_val ({6'h00, PHY_ADDR} ^ fpc_pkg::LFSR_SEED_XOR),
    .step     (1'b1),
    .key_bit  (tkey)
  );

  assign tline_bit = tsh_q[4] ^ tkey;

  logic tnrzi_q;
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      tnrzi_q <= 1'b0;
    else
      tnrzi_q <= tnrzi_q ^ tline_bit;
  end

  // line code carries the NRZI transitions, i.e. the scrambled code bits
  fpc_mlt3 u_tx_mlt3 (
    .clk      (CLK),
    .rst_n    (rst_n),
    .bit_en   (1'b1),
    .code_bit (tline_bit),
    .level    (TX_LEVEL)
  );

  // ************************************************************
  // receive line decode and descrambler
  // ************************************************************
  logic [1:0]  rlvl_q;
  logic        rbit;
  logic [10:0] rkey_q, rkey_d;
  logic        rlock_q, rlock_d;
  logic [3:0]  ridl_q, ridl_d;
  logic [12:0] rwin_q, rwin_d;
  logic        rplain;
  logic [4:0]  rsh_q, rsh_d;

  assign rbit   = (RX_LEVEL != rlvl_q);
  // idle is all ones, so scrambled bit is the inverted key bit while idle
  assign rplain = rbit ^ (rkey_q[10] ^ rkey_q[8]);

  always_comb
  begin
    rkey_d  = {rkey_q[9:0], rkey_q[10] ^ rkey_q[8]};
    rlock_d = rlock_q;
    ridl_d  = ridl_q;
    rwin_d  = rwin_q + 13'h1;
    if (!rlock_q)
    begin
      rkey_d = {rkey_q[9:0], ~rbit};
      ridl_d = rplain ? ridl_q + 4'h1 : 4'h0;
      if (ridl_q == 4'(fpc_pkg::LOCK_IDLE_CG * 5))
        rlock_d = 1'b1;
      rwin_d = 13'h0;
    end
    else if (rsh_q == fpc_pkg::CG_IDLE)
      rwin_d = 13'h0;
    else if (rwin_q == 13'(fpc_pkg::IDLE_WIN_CYC))
    begin
      rlock_d = 1'b0;
      ridl_d  = 4'h0;
      rwin_d  = 13'h0;
    end
    if (!LINE_SIGNAL_PRESENT)
      rlock_d = 1'b0;
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rlvl_q  <= fpc_pkg::LINE_ZERO;
      rkey_q  <= 11'h000;
      rlock_q <= 1'b0;
      ridl_q  <= 4'h0;
      rwin_q  <= 13'h0;
      rsh_q   <= 5'h00;
    end
    else
    begin
      rlvl_q  <= RX_LEVEL;
      rkey_q  <= rkey_d;
      rlock_q <= rlock_d;
      ridl_q  <= ridl_d;
      rwin_q  <= rwin_d;
      rsh_q   <= rsh_d;
    end
  end

  assign rsh_d = {rsh_q[3:0], rplain};

  // ************************************************************
  // alignment, decode and MII receive
  // ************************************************************
  fpc_pkg::fpc_rx_e rst_q, rst_d;
  logic [2:0] rcnt_q, rcnt_d;
  logic       cg_stb;
  logic [4:0] dec;
  logic [3:0] rxd_q, rxd_d;
  // one nibble of delay makes room for the second preamble nibble
  logic [3:0] hold_q, hold_d;
  logic       rxdv_q, rxdv_d, rxer_q, rxer_d, crs_q, crs_d;
  logic       prev_idle_q, prev_idle_d;
  logic       rclk_q, rclk_d;
  logic [2:0] fclk_q, fclk_d;

  assign cg_stb = (rcnt_q == fpc_pkg::BIT_LAST);
  assign dec    = fpc_pkg::dec5b4b(rsh_q);

  always_comb
  begin
    rst_d       = rst_q;
    rcnt_d      = cg_stb ? 3'h0 : rcnt_q + 3'h1;
    rxd_d       = rxd_q;
    hold_d      = hold_q;
    rxdv_d      = rxdv_q;
    rxer_d      = rxer_q;
    crs_d       = crs_q;
    prev_idle_d = prev_idle_q;
    unique case (rst_q)
      fpc_pkg::RX_IDLE:
      begin
        rxer_d = 1'b0;
        if (rlock_q && rsh_q == fpc_pkg::CG_J)
        begin
          rst_d  = fpc_pkg::RX_SSD_K;
          rcnt_d = 3'h0;
          crs_d  = 1'b1;
        end
      end
      fpc_pkg::RX_SSD_K:
        if (cg_stb)
        begin
          if (rsh_q == fpc_pkg::CG_K)
          begin
            rst_d  = fpc_pkg::RX_FRAME;
            rxd_d  = fpc_pkg::NIB_PRE;
            hold_d = fpc_pkg::NIB_PRE;
            rxdv_d = 1'b1;
          end
          else
          begin
            rst_d  = fpc_pkg::RX_IDLE;
            rxd_d  = fpc_pkg::NIB_BAD_SSD;
            rxer_d = 1'b1;
            crs_d  = 1'b0;
          end
        end
      fpc_pkg::RX_FRAME:
        if (cg_stb)
        begin
          rxer_d      = 1'b0;
          rxd_d       = hold_q;
          prev_idle_d = (rsh_q == fpc_pkg::CG_IDLE);
          if (!dec[4])
            hold_d = dec[3:0];
          else if (rsh_q == fpc_pkg::CG_T)
            rst_d = fpc_pkg::RX_END_R;
          else if (rsh_q == fpc_pkg::CG_IDLE && prev_idle_q)
          begin
            rst_d  = fpc_pkg::RX_IDLE;
            rxdv_d = 1'b0;
            crs_d  = 1'b0;
          end
          else if (rsh_q != fpc_pkg::CG_IDLE)
            rxer_d = 1'b1;
        end
      fpc_pkg::RX_END_R:
        if (cg_stb)
        begin
          rst_d  = fpc_pkg::RX_IDLE;
          rxdv_d = 1'b0;
          crs_d  = 1'b0;
          rxer_d = (rsh_q != fpc_pkg::CG_R);
        end
    endcase
    if (!LINK_OK || !LINE_SIGNAL_PRESENT || !rlock_q)
    begin
      rst_d  = fpc_pkg::RX_IDLE;
      rxdv_d = 1'b0;
      crs_d  = 1'b0;
    end
  end

  // receive clock: with line signal present, rises two cycles after the nibble strobe, so data change while it is low
  always_comb
  begin
    fclk_d = (fclk_q == fpc_pkg::BIT_LAST) ? 3'h0 : fclk_q + 3'h1;
    rclk_d = LINE_SIGNAL_PRESENT ? (rcnt_q < 3'h2) : (fclk_q < 3'h2);
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q       <= fpc_pkg::RX_IDLE;
      rcnt_q      <= 3'h0;
      rxd_q       <= 4'h0;
      hold_q      <= 4'h0;
      rxdv_q      <= 1'b0;
      rxer_q      <= 1'b0;
      crs_q       <= 1'b0;
      prev_idle_q <= 1'b0;
      rclk_q      <= 1'b0;
      fclk_q      <= 3'h0;
    end
    else
    begin
      rst_q       <= rst_d;
      rcnt_q      <= rcnt_d;
      rxd_q       <= rxd_d;
      hold_q      <= hold_d;
      rxdv_q      <= rxdv_d;
      rxer_q      <= rxer_d;
      crs_q       <= crs_d;
      prev_idle_q <= prev_idle_d;
      rclk_q      <= rclk_d;
      fclk_q      <= fclk_d;
    end
  end

  assign RXD   = rxd_q;
  assign RXDV  = rxdv_q;
  assign RXER  = rxer_q;
  assign CRS   = crs_q;
  assign RXCLK = rclk_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_tx_jk_pair: assert property (@(posedge CLK) disable iff (!rst_n)
    (tcg_end && tstate_q == 2'h0 && TXEN) |=> (tsh_q == fpc_pkg::CG_J) ##5 (tsh_q == fpc_pkg::CG_K))
    else $error("start delimiter not J then K");
  a_tx_tr_pair: assert property (@(posedge CLK) disable iff (!rst_n)
    (tcg_end && tstate_q == 2'h2 && !TXEN) |=> (tsh_q == fpc_pkg::CG_T) ##5 (tsh_q == fpc_pkg::CG_R))
    else $error("end delimiter not T then R");
  a_tx_halt: assert property (@(posedge CLK) disable iff (!rst_n)
    (tcg_end && tstate_q == 2'h2 && TXEN && TXER) |=> (tsh_q == fpc_pkg::CG_H))
    else $error("halt not sent on transmit error");
  a_tx_data: assert property (@(posedge CLK) disable iff (!rst_n)
    (tcg_end && tstate_q == 2'h2 && TXEN && !TXER) |=> (tsh_q == fpc_pkg::enc4b5b($past(TXD))))
    else $error("data code-group mismatch");
  a_rx_ssd_nib: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(RXDV) |-> (RXD == fpc_pkg::NIB_PRE && $past(rst_q) == fpc_pkg::RX_SSD_K))
    else $error("valid rose without preamble nibble");
  a_rx_bad_ssd: assert property (@(posedge CLK) disable iff (!rst_n)
    (rst_q == fpc_pkg::RX_SSD_K && cg_stb && rsh_q != fpc_pkg::CG_K && LINK_OK
     && LINE_SIGNAL_PRESENT && rlock_q) |=> (RXER && !RXDV && RXD == fpc_pkg::NIB_BAD_SSD))
    else $error("bad start delimiter not flagged");
  a_rx_drop: assert property (@(posedge CLK) disable iff (!rst_n)
    (!LINK_OK || !LINE_SIGNAL_PRESENT) |=> !RXDV && !CRS)
    else $error("valid held without link");
  a_rx_lone_t: assert property (@(posedge CLK) disable iff (!rst_n)
    (rst_q == fpc_pkg::RX_END_R && cg_stb && rsh_q != fpc_pkg::CG_R) |=> RXER)
    else $error("lone end delimiter not flagged");
  a_rx_window: assert property (@(posedge CLK) disable iff (!rst_n)
    rwin_q <= 13'(fpc_pkg::IDLE_WIN_CYC))
    else $error("idle window overrun");

  c_tx_frame: cover property (@(posedge CLK) disable iff (!rst_n) tstate_q == 2'h3);
  c_rx_frame: cover property (@(posedge CLK) disable iff (!rst_n) $fell(RXDV) && !RXER);
  c_rx_lock:  cover property (@(posedge CLK) disable iff (!rst_n) $rose(rlock_q));
endmodule

// ==== shared/fpc_pkg.sv ====
/*
  fpc_pkg: constants for the 100BASE-TX coding layer (4B/5B, scrambler, line code).
  assumes one 100 MHz core clock CLK; nibble timing made by a divide-by-5.
*/
package fpc_pkg;
  // ************************************************************
  // code-groups
  // ************************************************************
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0d;
  localparam logic [4:0] CG_R    = 5'h07;
  localparam logic [4:0] CG_H    = 5'h04;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'he;
  localparam logic [4:0] NIB_FLAG = 5'h10;
  // ************************************************************
  // scrambler and timing
  // ************************************************************
  localparam int         LFSR_W       = 11;
  localparam logic [10:0] LFSR_SEED_XOR = 11'h5a5;
  localparam logic [2:0]  BITS_PER_CG  = 3'h5;
  localparam logic [2:0]  BIT_LAST     = 3'h4;
  localparam int          CLK_MHZ      = 100;
  localparam int          IDLE_WIN_US  = 40;
  localparam int          IDLE_WIN_CYC = IDLE_WIN_US * CLK_MHZ;
  localparam logic [3:0]  LOCK_IDLE_CG = 4'h3;
  localparam logic [1:0]  LINE_ZERO    = 2'h0;
  localparam logic [1:0]  LINE_POS     = 2'h1;
  localparam logic [1:0]  LINE_NEG     = 2'h3;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_SSD_K = 2'b01,
    RX_FRAME = 2'b10,
    RX_END_R = 2'b11
  } fpc_rx_e;

  function automatic logic [4:0] enc4b5b(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h00;
    unique case (n)
      4'h0: c = 5'h1e; 4'h1: c = 5'h09; 4'h2: c = 5'h14; 4'h3: c = 5'h15;
      4'h4: c = 5'h0a; 4'h5: c = 5'h0b; 4'h6: c = 5'h0e; 4'h7: c = 5'h0f;
      4'h8: c = 5'h12; 4'h9: c = 5'h13; 4'ha: c = 5'h16; 4'hb: c = 5'h17;
      4'hc: c = 5'h1a; 4'hd: c = 5'h1b; 4'he: c = 5'h1c; 4'hf: c = 5'h1d;
    endcase
    return c;
  endfunction

  // bit 4 set marks a non-data code-group
  function automatic logic [4:0] dec5b4b(input logic [4:0] c);
    logic [4:0] r;
    r = NIB_FLAG;
    for (int i = 0; i < 16; i++)
      if (enc4b5b(4'(i)) == c)
        r = {1'b0, 4'(i)};
    return r;
  endfunction
endpackage

// ==== core/fpc_scram.sv ====
/*
  fpc_scram: 11-bit key generator, x^11 + x^9 + 1, one step per serial bit.
  assumes load has priority over step; the key is only read, never exported raw.
*/
`timescale 1ns/100ps
module fpc_scram (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic        load,
  input  wire logic [10:0] load_val,
  input  wire logic        step,
  // key bit
  output logic             key_bit
);
  logic [10:0] key_q;
  logic [10:0] key_d;

  always_comb
  begin
    key_d = key_q;
    if (load)
      key_d = load_val;
    else if (step)
      key_d = {key_q[9:0], key_q[10] ^ key_q[8]};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      key_q <= 11'h7ff;
    else
      key_q <= key_d;
  end

  assign key_bit = key_q[10] ^ key_q[8];
endmodule

// ==== core/fpc_mlt3.sv ====
/*
  fpc_mlt3: NRZI to three-level line encoder (0, +1, 0, -1 cycle).
  assumes one code bit per bit_en strobe; level held between strobes.
*/
`timescale 1ns/100ps
module fpc_mlt3 (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bit in
  input  wire logic       bit_en,
  input  wire logic       code_bit,
  // line out, two's complement level
  output logic [1:0]      level
);
  logic [1:0] lvl_q, lvl_d;
  logic       up_q, up_d;

  always_comb
  begin
    lvl_d = lvl_q;
    up_d  = up_q;
    if (bit_en && code_bit)
    begin
      if (lvl_q == fpc_pkg::LINE_ZERO)
        lvl_d = up_q ? fpc_pkg::LINE_POS : fpc_pkg::LINE_NEG;
      else
      begin
        lvl_d = fpc_pkg::LINE_ZERO;
        up_d  = (lvl_q == fpc_pkg::LINE_NEG);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_q <= fpc_pkg::LINE_ZERO;
      up_q  <= 1'b1;
    end
    else
    begin
      lvl_q <= lvl_d;
      up_q  <= up_d;
    end
  end

  assign level = lvl_q;
endmodule

// ==== bench/fpc_mac_model.sv ====
/*
  fpc_mac_model: mac side of the internal mii. sends nibbles on the
  transmit strobe and records every received nibble.
  assumes the line is looped back outside this model.
*/
`timescale 1ns/100ps
module fpc_mac_model (
  // clock
  input  wire logic       clk,
  // transmit mii
  input  wire logic       tx_nib_stb,
  output logic [3:0]      txd,
  output logic            txen,
  output logic            txer,
  // receive mii
  input  wire logic [3:0] rxd,
  input  wire logic       rxdv,
  input  wire logic       rxer
);
  logic [3:0] rx_q [$];
  logic       rx_err_seen;
  int         ph;

  initial
  begin
    txd = 4'h0;
    txen = 1'b0;
    txer = 1'b0;
    rx_err_seen = 1'b0;
    ph = 0;
  end

  // ************************************************************
  // transmit
  // ************************************************************
  // hold everything until the edge that takes it, then move on
  task automatic wait_take();
    do @(posedge clk); while (tx_nib_stb !== 1'b1);
    #1;
  endtask

  task automatic send(input logic [3:0] nib [$], input int err_at);
    foreach (nib[i])
    begin
      txen = 1'b1;
      txd = nib[i];
      txer = (i == err_at);
      wait_take();
    end
    txen = 1'b0;
    txer = 1'b0;
    txd = 4'ha;
    wait_take();
  endtask

  // ************************************************************
  // receive
  // ************************************************************
  // sample mid-nibble; each nibble stands five cycles
  always @(posedge clk)
  begin
    if (rxdv === 1'b1)
    begin
      if (ph == 2)
        rx_q.push_back(rxd);
      ph = (ph == 4) ? 0 : ph + 1;
    end
    else
      ph = 0;
    if (rxer === 1'b1)
      rx_err_seen = 1'b1;
  end
endmodule

// ==== bench/fpc_coding_tb.sv ====
/*
  fpc_coding_tb: self-checking bench for fpc_coding, line looped back.
  assumes the mac model in fpc_mac_model and a 100 MHz clock.
*/
`timescale 1ns/100ps
module fpc_coding_tb;
  logic       CLK, RESETN, LINE_SIGNAL_PRESENT, LINK_OK, line_cut;
  logic [4:0] PHY_ADDR;
  logic [3:0] TXD, RXD;
  logic       TXEN, TXER, TX_NIB_STB, RXCLK, RXDV, RXER, CRS;
  logic [1:0] TX_LEVEL, RX_LEVEL, lv_prev, lv_nz;
  int         err_count, tests_run;

  initial
  begin
    CLK = 1'b0;
    RESETN = 1'b0;
    PHY_ADDR = 5'h00;
    LINE_SIGNAL_PRESENT = 1'b1;
    LINK_OK = 1'b1;
    line_cut = 1'b0;
    err_count = 0;
    tests_run = 0;
  end

  always #5 CLK = ~CLK;
  // a cut line sits at the zero level
  assign RX_LEVEL = line_cut ? 2'h0 : TX_LEVEL;

  fpc_coding dut (.CLK(CLK), .RESETN(RESETN), .PHY_ADDR(PHY_ADDR), .TXD(TXD), .TXEN(TXEN),
    .TXER(TXER), .TX_NIB_STB(TX_NIB_STB), .TX_LEVEL(TX_LEVEL), .RX_LEVEL(RX_LEVEL),
    .LINE_SIGNAL_PRESENT(LINE_SIGNAL_PRESENT), .LINK_OK(LINK_OK), .RXCLK(RXCLK),
    .RXD(RXD), .RXDV(RXDV), .RXER(RXER), .CRS(CRS));

  fpc_mac_model mac (.clk(CLK), .tx_nib_stb(TX_NIB_STB), .txd(TXD), .txen(TXEN),
    .txer(TXER), .rxd(RXD), .rxdv(RXDV), .rxer(RXER));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // idle time after release lets the descrambler lock
  task automatic do_reset(input logic [4:0] addr);
    RESETN = 1'b0;
    PHY_ADDR = addr;
    repeat (20) @(posedge CLK);
    #1 RESETN = 1'b1;
    repeat (300) @(posedge CLK);
    #1;
  endtask

  task automatic settle();
    int quiet;
    quiet = 0;
    for (int n = 0; n < 600 && quiet < 30; n++)
    begin
      @(posedge CLK);
      quiet = (RXDV === 1'b0) ? quiet + 1 : 0;
    end
    #1;
  endtask

  function automatic void make_frame(ref logic [3:0] nib [$]);
    nib = {4'h5, 4'h5};
    for (int i = 0; i < 16; i++)
      nib.push_back(4'(i));
    mac.rx_q.delete();
    mac.rx_err_seen = 1'b0;
  endfunction

  // three-level code: step through 0, +1, 0, -1 or hold
  always @(posedge CLK)
    if (RESETN !== 1'b1)
    begin
      lv_prev <= 2'h0;
      lv_nz <= 2'h2;
    end
    else if (TX_LEVEL !== lv_prev)
    begin
      if (lv_prev !== 2'h0)
        check(TX_LEVEL, 2'h0, "line step");
      else if (lv_nz !== 2'h2)
        check(TX_LEVEL, lv_nz ^ 2'h2, "line step");
      lv_prev <= TX_LEVEL;
      if (TX_LEVEL !== 2'h0)
        lv_nz <= TX_LEVEL;
    end

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic seed_test();
    logic [119:0] s [3];
    for (int a = 0; a < 3; a++)
    begin
      do_reset(5'(a));
      for (int n = 0; n < 60; n++)
      begin
        @(posedge CLK);
        s[a] = {s[a][117:0], TX_LEVEL};
      end
    end
    #1;
    check(s[0] !== s[1] && s[1] !== s[2] && s[0] !== s[2], 1'b1, "seeds");
    $display("seed test done");
  endtask

  task automatic clean_test();
    logic [3:0] nib [$];
    make_frame(nib);
    mac.send(nib, -1);
    settle();
    check(mac.rx_q.size(), 18, "nibble count");
    foreach (nib[i])
      check(mac.rx_q[i], nib[i], "rx nibble");
    check(mac.rx_err_seen, 1'b0, "clean frame error");
    check(CRS, 1'b0, "carrier after end");
    $display("clean frame test done");
  endtask

  task automatic error_test();
    logic [3:0] nib [$];
    make_frame(nib);
    mac.send(nib, 7);
    settle();
    for (int i = 0; i < 7; i++)
      check(mac.rx_q[i], nib[i], "rx before error");
    check(mac.rx_err_seen, 1'b1, "halt seen as error");
    $display("error frame test done");
  endtask

  task automatic rxclk_check();
    int t0;
    int t1;
    logic p;
    t0 = -1;
    t1 = -1;
    p = RXCLK;
    for (int n = 0; n < 20; n++)
    begin
      @(posedge CLK);
      if (RXCLK === 1'b1 && p === 1'b0)
      begin
        if (t0 < 0)
          t0 = n;
        else if (t1 < 0)
          t1 = n;
      end
      p = RXCLK;
    end
    #1;
    check(t1 - t0, 5, "rxclk period");
  endtask

  task automatic loss_test(input logic cut);
    logic [3:0] nib [$];
    make_frame(nib);
    fork
      mac.send(nib, -1);
      begin
        repeat (50) @(posedge CLK);
        #1;
        check(RXDV, 1'b1, "frame active");
        if (cut)
        begin
          line_cut = 1'b1;
          LINE_SIGNAL_PRESENT = 1'b0;
        end
        else
          LINK_OK = 1'b0;
        repeat (12) @(posedge CLK);
        #1;
        check(RXDV, 1'b0, "valid after loss");
        rxclk_check();
        line_cut = 1'b0;
        LINE_SIGNAL_PRESENT = 1'b1;
        LINK_OK = 1'b1;
      end
    join
    settle();
    repeat (300) @(posedge CLK);
    #1;
    $display("loss test done");
  endtask

  // 1000 nibbles without idle outlast the 4000 cycle window
  task automatic long_test();
    logic [3:0] nib [$];
    for (int i = 0; i < 1000; i++)
      nib.push_back(4'ha);
    fork
      mac.send(nib, -1);
      begin
        repeat (3000) @(posedge CLK);
        #1;
        check(RXDV, 1'b1, "long frame inside window");
        repeat (1300) @(posedge CLK);
        #1;
        check(RXDV, 1'b0, "long frame aborted");
      end
    join
    settle();
    repeat (300) @(posedge CLK);
    #1;
    $display("window test done");
  endtask

  initial
  begin
    seed_test();
    rxclk_check();
    clean_test();
    clean_test();
    error_test();
    loss_test(1'b1);
    loss_test(1'b0);
    long_test();
    clean_test();
    conclude();
  end

  // runs are about 8000 cycles; five times that is a hang
  initial
  begin
    #400000;
    err_count++;
    conclude();
  end
endmodule
